//--- hw/smcr_pkg.sv
// Package: offsets, field layout, reset values and timing counts
package smcr_pkg;
    // ------------------------------------------------------------------
    // Register offsets on the IO address space
    // ------------------------------------------------------------------
    localparam logic [5:0] SMCR_OFS_MISC   = 6'h08;
    localparam logic [5:0] SMCR_OFS_EXTERNAL_CRYSTAL_OSC   = 6'h0A;
    localparam logic [5:0] SMCR_OFS_EDGE   = 6'h0C;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int SMCR_MISC_FAST_WAKE     = 5;
    localparam int SMCR_MISC_LVR_OFF       = 2;
    localparam int SMCR_MISC_WDT_LSB       = 0;
    localparam int SMCR_EXTERNAL_CRYSTAL_OSC_EN            = 7;
    localparam int SMCR_EXTERNAL_CRYSTAL_OSC_DRV_LSB       = 5;
    localparam int SMCR_EXTERNAL_CRYSTAL_OSC_BG_PD         = 0;
    localparam int SMCR_EDGE_TMR           = 4;
    localparam int SMCR_EDGE_PIN_A_LSB     = 2;
    localparam int SMCR_EDGE_PIN_B_LSB     = 0;

    // ------------------------------------------------------------------
    // Reset values and writable masks
    // ------------------------------------------------------------------
    localparam logic [7:0] SMCR_RST_MISC   = 8'h00;
    localparam logic [7:0] SMCR_RST_EXTERNAL_CRYSTAL_OSC   = 8'h00;
    localparam logic [7:0] SMCR_RST_EDGE   = 8'h00;
    localparam logic [7:0] SMCR_MASK_MISC  = 8'h27;
    localparam logic [7:0] SMCR_MASK_EXTERNAL_CRYSTAL_OSC  = 8'hE1;
    localparam logic [7:0] SMCR_MASK_EDGE  = 8'h1F;

    // ------------------------------------------------------------------
    // Edge and drive codes
    // ------------------------------------------------------------------
    localparam logic [1:0] SMCR_EDGE_BOTH  = 2'h0;
    localparam logic [1:0] SMCR_EDGE_RISE  = 2'h1;
    localparam logic [1:0] SMCR_EDGE_FALL  = 2'h2;
    localparam logic [1:0] SMCR_DRV_LOW    = 2'h1;
    localparam logic [1:0] SMCR_DRV_MID    = 2'h2;
    localparam logic [1:0] SMCR_DRV_HIGH   = 2'h3;

    // ------------------------------------------------------------------
    // Timing in low-speed RC clock cycles
    // ------------------------------------------------------------------
    localparam logic [11:0] SMCR_WAKE_NORMAL = 12'hBB8;
    localparam logic [11:0] SMCR_WAKE_FAST   = 12'h02D;
    localparam logic [17:0] SMCR_WDT_8K      = 18'h02000;
    localparam logic [17:0] SMCR_WDT_16K     = 18'h04000;
    localparam logic [17:0] SMCR_WDT_64K     = 18'h10000;
    localparam logic [17:0] SMCR_WDT_256K    = 18'h3FFFF;
endpackage : smcr_pkg

//--- hw/smcr_edge_det.sv
// Edge detector: one-cycle pulse on the configured edge
`timescale 1ns/1ns
`default_nettype none
module smcr_edge_det
    import smcr_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       resetn_i,
    // Source and mode
    input  wire logic       sig_i,
    input  wire logic [1:0] mode_i,
    // Event
    output logic            pulse_o
);
    logic prev_r;
    logic rise;
    logic fall;

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= sig_i;
        end
    end

    assign rise = sig_i & ~prev_r;
    assign fall = ~sig_i & prev_r;

    // R15: compare with previous
    always_comb begin
        case (mode_i)
            SMCR_EDGE_BOTH: pulse_o = rise | fall;
            SMCR_EDGE_RISE: pulse_o = rise;
            SMCR_EDGE_FALL: pulse_o = fall;
            // Reserved code raises nothing
            default:        pulse_o = 1'b0;
        endcase
    end
endmodule : smcr_edge_det
`default_nettype wire

//--- hw/smcr_top.sv
// System misc configuration registers with wake and edge logic
// Operation
// R1: normal wake holds 3000 slow RC cycles
// R2: fast wake bit shortens to 45
// R3: software avoids fast wake with crystal
// R4: bit 2 disables low voltage reset
// R5: watchdog code picks 8k..256k periods; code 3 gives 18'h3FFFF, one short of 256k
// R6: bit 7 enables external crystal
// R7: drive field low/mid/high, 00 reserved
// R8: bit 0 powers down bandgap, reset
// R9: bandgap down leaves few functions usable
// R10: timer edge bit picks rise/fall
// R11: pin fields pick both/rise/fall
// R12: software writes zero to reserved bits
// R13: timer event from bit 8..15 change
// R14: edge sets sticky flag until cleared
// R15: pins sampled, edge pulsed one cycle
`timescale 1ns/1ns
`default_nettype none
module smcr_top
    import smcr_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        resetn_i,
    // IO write port
    input  wire logic        io_wr_i,
    input  wire logic [5:0]  io_addr_i,
    input  wire logic [7:0]  io_wdata_i,
    // Low-speed RC oscillator tick
    input  wire logic        slow_rc_tick_i,
    // Wake-up control
    input  wire logic        wake_start_i,
    output logic             wake_busy_o,
    // Event sources
    input  wire logic [15:0] timer_count_i,
    input  wire logic [2:0]  timer_bit_sel_i,
    input  wire logic        pin_a_i,
    input  wire logic        pin_b_i,
    // Request flag clear
    input  wire logic [2:0]  irq_clear_i,
    // Request flags: timer, pin a, pin b
    output logic [2:0]       irq_flag_o,
    // Analog and oscillator controls
    output logic             low_voltage_reset_en_o,
    output logic             bandgap_pd_o,
    output logic             external_crystal_osc_en_o,
    output logic [1:0]       crystal_drive_o,
    output logic             crystal_drive_valid_o,
    output logic             analog_funcs_avail_o,
    output logic [17:0]      wdt_period_o
);
    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [7:0] misc_wake_watchdog_ctrl_r;
    logic [7:0] ext_osc_setting_r;
    logic [7:0] irq_edge_select_r;

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            misc_wake_watchdog_ctrl_r <= SMCR_RST_MISC;
        end else if (io_wr_i && io_addr_i == SMCR_OFS_MISC) begin
            misc_wake_watchdog_ctrl_r <= io_wdata_i & SMCR_MASK_MISC;
        end
    end

    // R12: reserved bits dropped
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ext_osc_setting_r <= SMCR_RST_EXTERNAL_CRYSTAL_OSC;
        end else if (io_wr_i && io_addr_i == SMCR_OFS_EXTERNAL_CRYSTAL_OSC) begin
            ext_osc_setting_r <= io_wdata_i & SMCR_MASK_EXTERNAL_CRYSTAL_OSC;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_edge_select_r <= SMCR_RST_EDGE;
        end else if (io_wr_i && io_addr_i == SMCR_OFS_EDGE) begin
            irq_edge_select_r <= io_wdata_i & SMCR_MASK_EDGE;
        end
    end

    // ------------------------------------------------------------------
    // Control outputs
    // ------------------------------------------------------------------
    logic [1:0] drv;
    assign drv = ext_osc_setting_r[SMCR_EXTERNAL_CRYSTAL_OSC_DRV_LSB +: 2];

    // R4: low voltage reset enable
    assign low_voltage_reset_en_o =
        ~misc_wake_watchdog_ctrl_r[SMCR_MISC_LVR_OFF] &
        ~ext_osc_setting_r[SMCR_EXTERNAL_CRYSTAL_OSC_BG_PD];
    // R8: bandgap power-down
    assign bandgap_pd_o = ext_osc_setting_r[SMCR_EXTERNAL_CRYSTAL_OSC_BG_PD];
    // R9: analog functions gated
    assign analog_funcs_avail_o = ~ext_osc_setting_r[SMCR_EXTERNAL_CRYSTAL_OSC_BG_PD];
    // R6: crystal enable
    assign external_crystal_osc_en_o = ext_osc_setting_r[SMCR_EXTERNAL_CRYSTAL_OSC_EN];
    // R7: reserved drive code flagged
    assign crystal_drive_o = drv;
    assign crystal_drive_valid_o = (drv == SMCR_DRV_LOW) ||
                                   (drv == SMCR_DRV_MID) ||
                                   (drv == SMCR_DRV_HIGH);

    // R5: watchdog period decode
    always_comb begin
        case (misc_wake_watchdog_ctrl_r[SMCR_MISC_WDT_LSB +: 2])
            2'h0:    wdt_period_o = SMCR_WDT_8K;
            2'h1:    wdt_period_o = SMCR_WDT_16K;
            2'h2:    wdt_period_o = SMCR_WDT_64K;
            2'h3:    wdt_period_o = SMCR_WDT_256K;
            default: wdt_period_o = SMCR_WDT_8K;
        endcase
    end

    // ------------------------------------------------------------------
    // Wake-up delay counter
    // ------------------------------------------------------------------
    // Fast wake is not supported with the crystal running; the length
    // is still honoured as written, software must avoid it.
    logic [11:0] wake_cnt_r;
    logic [11:0] wake_len;

    // R1: normal wake length
    // R2: fast wake length
    assign wake_len = misc_wake_watchdog_ctrl_r[SMCR_MISC_FAST_WAKE] ?
                      SMCR_WAKE_FAST : SMCR_WAKE_NORMAL;

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wake_cnt_r <= 12'h000;
        end else if (wake_start_i && wake_cnt_r == 12'h000) begin
            wake_cnt_r <= wake_len;
        end else if (slow_rc_tick_i && wake_cnt_r != 12'h000) begin
            wake_cnt_r <= wake_cnt_r - 12'h001;
        end
    end

    assign wake_busy_o = (wake_cnt_r != 12'h000);

    // ------------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------------
    logic [2:0] src;
    logic [1:0] mode [3];
    logic [2:0] hit;

    // R13: timer bit 8..15 select
    assign src[0] = timer_count_i[4'h8 + {1'b0, timer_bit_sel_i}];
    assign src[1] = pin_a_i;
    assign src[2] = pin_b_i;
    // R10: timer rise or fall
    assign mode[0] = irq_edge_select_r[SMCR_EDGE_TMR] ?
                     SMCR_EDGE_FALL : SMCR_EDGE_RISE;
    // R11: pin edge fields
    assign mode[1] = irq_edge_select_r[SMCR_EDGE_PIN_A_LSB +: 2];
    assign mode[2] = irq_edge_select_r[SMCR_EDGE_PIN_B_LSB +: 2];

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_src
            smcr_edge_det u_det (
                .sys_clk_i (sys_clk_i),
                .resetn_i  (resetn_i),
                .sig_i     (src[gi]),
                .mode_i    (mode[gi]),
                .pulse_o   (hit[gi])
            );
            // R14: set wins over clear
            always_ff @(posedge sys_clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    irq_flag_o[gi] <= 1'b0;
                end else if (hit[gi]) begin
                    irq_flag_o[gi] <= 1'b1;
                end else if (irq_clear_i[gi]) begin
                    irq_flag_o[gi] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule : smcr_top
`default_nettype wire

//--- tb/smcr_top_chk.sv
// Checker: port assertions for the system config registers
`timescale 1ns/1ns
`default_nettype none
module smcr_top_chk
    import smcr_pkg::*;
(
    // Clock, reset and write port
    input wire logic        sys_clk_i,
    input wire logic        resetn_i,
    input wire logic        io_wr_i,
    input wire logic [5:0]  io_addr_i,
    input wire logic [7:0]  io_wdata_i,
    // Wake and events
    input wire logic        wake_start_i,
    input wire logic        wake_busy_o,
    input wire logic        pin_b_i,
    input wire logic [2:0]  irq_clear_i,
    input wire logic [2:0]  irq_flag_o,
    // Controls
    input wire logic        low_voltage_reset_en_o,
    input wire logic        bandgap_pd_o,
    input wire logic [1:0]  crystal_drive_o,
    input wire logic        crystal_drive_valid_o,
    input wire logic        analog_funcs_avail_o,
    input wire logic [17:0] wdt_period_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    logic wr_misc;
    logic wr_external_crystal_osc;
    assign wr_misc = io_wr_i && io_addr_i == SMCR_OFS_MISC;
    assign wr_external_crystal_osc = io_wr_i && io_addr_i == SMCR_OFS_EXTERNAL_CRYSTAL_OSC;

    chk_lvr_off: assert property (
        wr_misc && io_wdata_i[2] |=> !low_voltage_reset_en_o)
        else $error("lvr still on");
    chk_bg_pd: assert property (
        wr_external_crystal_osc |=> bandgap_pd_o == $past(io_wdata_i[0]))
        else $error("bandgap bit wrong");
    chk_drv_valid: assert property (
        crystal_drive_valid_o == (crystal_drive_o != 2'h0))
        else $error("drive valid wrong");
    chk_func_avail: assert property (
        analog_funcs_avail_o == !bandgap_pd_o)
        else $error("avail wrong");
    chk_wdt_max: assert property (
        wr_misc && io_wdata_i[1:0] == 2'h3 |=> wdt_period_o == 18'h3FFFF)
        else $error("wdt period wrong");
    chk_wake_start: assert property (
        wake_start_i && !wake_busy_o |=> wake_busy_o)
        else $error("wake not started");
    chk_wake_min: assert property (
        $rose(wake_busy_o) |-> wake_busy_o [*8])
        else $error("wake too short");
    chk_flag_hold: assert property (
        irq_flag_o[2] && !irq_clear_i[2] |=> irq_flag_o[2])
        else $error("flag lost");
    chk_flag_clear: assert property (
        $past(resetn_i) && irq_clear_i[2] && $stable(pin_b_i)
        |=> !irq_flag_o[2])
        else $error("flag not cleared");
endmodule : smcr_top_chk
bind smcr_top smcr_top_chk u_chk (.*);
`default_nettype wire

//--- tb/test_system_misc_config_regs.sv
// Testbench: self-checking bench for the config registers
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((e) !== (s)) begin \
    errors++; $display("BAD %s exp %h got %h", n, e, s); end end
module test_system_misc_config_regs;
    import smcr_pkg::*;
    logic sys_clk_i, resetn_i, io_wr_i, slow_rc_tick_i, wake_start_i;
    logic pin_a_i, pin_b_i, wake_busy_o, low_voltage_reset_en_o;
    logic bandgap_pd_o, external_crystal_osc_en_o, crystal_drive_valid_o;
    logic analog_funcs_avail_o;
    logic [5:0]  io_addr_i;
    logic [7:0]  io_wdata_i, misc_m, external_crystal_osc_m, d;
    logic [15:0] timer_count_i;
    logic [2:0]  timer_bit_sel_i, irq_clear_i, irq_flag_o;
    logic [1:0]  crystal_drive_o;
    logic [17:0] wdt_period_o;
    logic [31:0] seed;
    logic [28:0] q[$], exp_v, obs;
    int          errors, cmp_count;
    assign obs = {irq_flag_o, low_voltage_reset_en_o, bandgap_pd_o,
        external_crystal_osc_en_o, crystal_drive_o, crystal_drive_valid_o,
        analog_funcs_avail_o, wdt_period_o, wake_busy_o};
    smcr_top u_smcr_top (.*);
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    function automatic logic [28:0] expv(input logic [2:0] f, input logic b);
        logic [17:0] w;
        case (misc_m[1:0])
            2'h0: w = 18'h02000;
            2'h1: w = 18'h04000;
            2'h2: w = 18'h10000;
            default: w = 18'h3FFFF;
        endcase
        return {f, ~misc_m[2] & ~external_crystal_osc_m[0], external_crystal_osc_m[0], external_crystal_osc_m[7],
            external_crystal_osc_m[6:5], external_crystal_osc_m[6:5] != 2'h0, ~external_crystal_osc_m[0], w, b};
    endfunction : expv
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        @(negedge sys_clk_i);
        io_wr_i = 1'b1;
        io_addr_i = a;
        io_wdata_i = v;
        @(negedge sys_clk_i);
        io_wr_i = 1'b0;
    endtask : wr
    task automatic note(input logic [2:0] f, input logic b);
        q.push_back(expv(f, b));
        @(negedge sys_clk_i);
    endtask : note
    task automatic clr;
        irq_clear_i = 3'h7;
        @(negedge sys_clk_i);
        irq_clear_i = 3'h0;
    endtask : clr
    // Busy must last exactly n slow ticks
    task automatic wake(input int n);
        wake_start_i = 1'b1;
        @(negedge sys_clk_i);
        wake_start_i = 1'b0;
        slow_rc_tick_i = 1'b1;
        repeat (n - 1) @(negedge sys_clk_i);
        note(3'h0, 1'b1);
        slow_rc_tick_i = 1'b0;
        note(3'h0, 1'b0);
    endtask : wake
    task automatic final_report;
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report
    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        if (q.size() > 0) begin
            exp_v = q.pop_front();
            `CHK("obs", exp_v, obs)
        end
    end
    initial begin
        #80000;
        errors++;
        final_report();
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {resetn_i, io_wr_i, io_addr_i, io_wdata_i, slow_rc_tick_i} = '0;
        {wake_start_i, timer_count_i, timer_bit_sel_i} = '0;
        {pin_a_i, pin_b_i, irq_clear_i, misc_m, external_crystal_osc_m} = '0;
        seed = 32'h00014AF6;
        repeat (2) @(negedge sys_clk_i);
        resetn_i = 1'b1;
        note(3'h0, 1'b0);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            wr(SMCR_OFS_MISC, {seed[7:2], 2'(i)});
            misc_m = {seed[7:2], 2'(i)} & 8'h27;
            note(3'h0, 1'b0);
            d = (i == 0) ? 8'h81 : {seed[15], 2'(i), 4'h0, seed[8]};
            wr(SMCR_OFS_EXTERNAL_CRYSTAL_OSC, d);
            external_crystal_osc_m = d & 8'hE1;
            note(3'h0, 1'b0);
        end
        // Unmapped address must leave every control unchanged
        wr(6'h09, 8'hFF);
        note(3'h0, 1'b0);
        wr(SMCR_OFS_MISC, 8'h00);
        misc_m = 8'h00;
        wake(3000);
        wr(SMCR_OFS_EXTERNAL_CRYSTAL_OSC, 8'h20);
        external_crystal_osc_m = 8'h20;
        wr(SMCR_OFS_MISC, 8'h20);
        misc_m = 8'h20;
        wake(45);
        for (int m = 0; m < 4; m++) begin
            wr(SMCR_OFS_EDGE, {4'h0, 2'(m), 2'(m)});
            {pin_a_i, pin_b_i} = 2'h3;
            @(negedge sys_clk_i);
            note((m < 2) ? 3'h6 : 3'h0, 1'b0);
            clr();
            {pin_a_i, pin_b_i} = 2'h0;
            @(negedge sys_clk_i);
            note((m == 0 || m == 2) ? 3'h6 : 3'h0, 1'b0);
            clr();
        end
        for (int e = 0; e < 2; e++) begin
            wr(SMCR_OFS_EDGE, {3'h0, 1'(e), 4'h0});
            seed = lfsr(seed);
            timer_bit_sel_i = seed[2:0];
            @(negedge sys_clk_i);
            timer_count_i = (16'h0100 << seed[2:0]) | {8'h00, seed[15:8]};
            @(negedge sys_clk_i);
            note({2'h0, e == 0}, 1'b0);
            clr();
            timer_count_i = {8'h00, seed[23:16]};
            @(negedge sys_clk_i);
            note({2'h0, e == 1}, 1'b0);
            clr();
        end
        repeat (2) @(negedge sys_clk_i);
        final_report();
    end
endmodule : test_system_misc_config_regs
`default_nettype wire
